// ---- rrtp_ctrl.sv ----
// Receive frame gate and transmit start and power sequencing.
// Assumes synchronous inputs on ref_clk and an AXI4-Lite master.
// Notes on behaviour
// - Block bit set stops new frame starts.
// - Frame already in progress completes normally.
// - Blocking applies whatever threshold is programmed.
// - Threshold zero accepts every valid frame.
// - Nonzero threshold: strength above floor plus steps.
// - Output level code drives transmit power.
// - Transmit starts only from locked or retry.
// - Trigger edge enters transmit; modulation after 16us.
// - Buffer enabled first, amplifier afterwards.
//
// Our own choice: the AXI4-Lite register port.
module rrtp_ctrl
  import rrtp_pkg::*;
#(
  parameter int MOD_CYC = RRTP_MOD_CYC,
  parameter int FLOOR_DBM = -91
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_tx_trigger_pin,
  input wire logic syncDetect,
  input wire logic signed [7:0] frameStrengthDbm,
  input wire logic rxFrameEnd,
  input wire logic txFrameEnd,
  output logic frameAccept_q,
  output logic [3:0] txOutputLevel_q,
  output logic paBufEn_q,
  output logic paEn_q,
  output logic modulate_q
);
  localparam int CW = $clog2(MOD_CYC + 1);
  localparam int BUF_AT = MOD_CYC / 4;
  localparam int PA_AT = MOD_CYC / 2;

  logic [3:0] rxDetectThreshold_q;
  logic rxPathBlock_q;
  logic autoCrc_q;
  rrtp_state_t state_q;
  logic trigPrev_q;
  logic [CW-1:0] txCnt_q;
  logic [CW-1:0] sinceStart_q;
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic cmdStrobe;
  logic [4:0] cmdCode;
  logic trigEdge;
  logic startTx;
  logic strongEnough;
  logic signed [9:0] floorDbm;

  // Write channels are taken independently and combined once both are held.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !wHeld_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (awHeld_q && wHeld_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q == RRTP_TXPWR_ADDR || awAddr_q == RRTP_RXSYN_ADDR ||
                        awAddr_q == RRTP_CMD_ADDR || awAddr_q == RRTP_STAT_ADDR) ?
                       2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire doWrite = awHeld_q && wHeld_q && wStrb_q[0];
  assign cmdStrobe = doWrite && (awAddr_q == RRTP_CMD_ADDR);
  assign cmdCode = wData_q[4:0];

  // Software-written configuration registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      txOutputLevel_q <= RRTP_LEVEL_RST;
      autoCrc_q <= 1'b0;
      rxDetectThreshold_q <= RRTP_THRESH_RST;
      rxPathBlock_q <= RRTP_BLOCK_RST;
    end else if (doWrite) begin
      if (awAddr_q == RRTP_TXPWR_ADDR) begin
        txOutputLevel_q <= wData_q[3:0];
        autoCrc_q <= wData_q[RRTP_AUTOCRC_BIT];
      end
      if (awAddr_q == RRTP_RXSYN_ADDR) begin
        rxDetectThreshold_q <= wData_q[3:0];
        rxPathBlock_q <= wData_q[RRTP_BLOCK_BIT];
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          RRTP_TXPWR_ADDR: s_axi_rdata <= {24'h000000, autoCrc_q, 3'h0, txOutputLevel_q};
          RRTP_RXSYN_ADDR: s_axi_rdata <= {24'h000000, rxPathBlock_q, 3'h0, rxDetectThreshold_q};
          RRTP_CMD_ADDR: s_axi_rdata <= 32'h00000000;
          RRTP_STAT_ADDR: s_axi_rdata <= {25'h0000000, paEn_q, paBufEn_q, modulate_q,
                                          1'b0, state_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Trigger pin edge detection; the pin is already synchronous.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= sleep_tx_trigger_pin;
    end
  end

  assign trigEdge = sleep_tx_trigger_pin && !trigPrev_q;
  // Only the locked and retry states may start a frame.
  assign startTx = (trigEdge || (cmdStrobe && cmdCode == RRTP_CMD_TX_START)) &&
                   (state_q == RRTP_LOCKED || state_q == RRTP_ARETON);

  // Strength check: floor plus 3 dB per step above one.
  assign floorDbm = 10'(FLOOR_DBM) + 10'(RRTP_STEP_DB) * ($signed({6'h00, rxDetectThreshold_q}) - 10'sd1);
  assign strongEnough = (rxDetectThreshold_q == 4'h0) ||
                        ($signed({{2{frameStrengthDbm[7]}}, frameStrengthDbm}) > floorDbm);

  // Transceiver state machine; a blocked gate never takes a listen state into BUSYRX.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= RRTP_IDLE;
      frameAccept_q <= 1'b0;
    end else begin
      frameAccept_q <= 1'b0;
      case (state_q)
        RRTP_IDLE, RRTP_LOCKED: begin
          if (startTx) begin
            state_q <= RRTP_BUSYTX;
          end else if (cmdStrobe && cmdCode == RRTP_CMD_PLL_ON) begin
            state_q <= RRTP_LOCKED;
          end else if (cmdStrobe && cmdCode == RRTP_CMD_RX_ON) begin
            state_q <= RRTP_RXON;
          end else if (cmdStrobe && cmdCode == RRTP_CMD_AACK_ON) begin
            state_q <= RRTP_AACKON;
          end else if (cmdStrobe && cmdCode == RRTP_CMD_ARET_ON) begin
            state_q <= RRTP_ARETON;
          end
        end
        RRTP_RXON, RRTP_AACKON: begin
          if (syncDetect && !rxPathBlock_q && strongEnough) begin
            state_q <= RRTP_BUSYRX;
            frameAccept_q <= 1'b1;
          end else if (cmdStrobe && cmdCode == RRTP_CMD_PLL_ON) begin
            state_q <= RRTP_LOCKED;
          end
        end
        RRTP_BUSYRX: begin
          // The block bit is not looked at here, so a frame in flight ends normally.
          if (rxFrameEnd) begin
            state_q <= RRTP_RXON;
          end
        end
        RRTP_ARETON: begin
          if (startTx) begin
            state_q <= RRTP_BUSYTX;
          end else if (cmdStrobe && cmdCode == RRTP_CMD_PLL_ON) begin
            state_q <= RRTP_LOCKED;
          end
        end
        RRTP_BUSYTX: begin
          if (txFrameEnd && modulate_q) begin
            state_q <= RRTP_LOCKED;
          end
        end
        default: state_q <= RRTP_IDLE;
      endcase
    end
  end

  // Power ramp: buffer, then amplifier, then modulation at the full count.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      txCnt_q <= '0;
      paBufEn_q <= 1'b0;
      paEn_q <= 1'b0;
      modulate_q <= 1'b0;
    end else if (startTx) begin
      txCnt_q <= CW'(1);
      paBufEn_q <= 1'b0;
      paEn_q <= 1'b0;
      modulate_q <= 1'b0;
    end else if (state_q == RRTP_BUSYTX) begin
      if (txCnt_q != CW'(MOD_CYC)) begin
        txCnt_q <= txCnt_q + CW'(1);
      end
      if (txCnt_q == CW'(BUF_AT)) begin
        paBufEn_q <= 1'b1;
      end
      if (txCnt_q == CW'(PA_AT)) begin
        paEn_q <= 1'b1;
      end
      if (txCnt_q == CW'(MOD_CYC - 1)) begin
        modulate_q <= 1'b1;
      end
    end else begin
      txCnt_q <= '0;
      paBufEn_q <= 1'b0;
      paEn_q <= 1'b0;
      modulate_q <= 1'b0;
    end
  end

  // Assertion helper: cycles since the transmit start. It is kept apart from the ramp
  // counter so that the delay check does not lean on the logic that it judges.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sinceStart_q <= '0;
    end else if (startTx) begin
      sinceStart_q <= CW'(1);
    end else if (state_q != RRTP_BUSYTX) begin
      sinceStart_q <= '0;
    end else if (sinceStart_q != CW'(MOD_CYC)) begin
      sinceStart_q <= sinceStart_q + CW'(1);
    end
  end

  // Modulation rises exactly MOD_CYC cycles after the transmit start.
  a_mod_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(modulate_q) |-> sinceStart_q == CW'(MOD_CYC))
    else $error("modulation did not start on time");
  // Once the full delay has run in the transmit state, modulation must be on.
  a_mod_on: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == RRTP_BUSYTX && sinceStart_q == CW'(MOD_CYC)) |-> modulate_q)
    else $error("modulation missing after the start delay");
  // A legal start always lands in the transmit state on the next edge.
  a_tx_enter: assert property (@(posedge ref_clk) disable iff (!nrst)
    startTx |=> state_q == RRTP_BUSYTX)
    else $error("transmit start did not enter the transmit state");
  // Amplifier never on without its buffer.
  a_ramp_order: assert property (@(posedge ref_clk) disable iff (!nrst)
    paEn_q |-> paBufEn_q)
    else $error("amplifier enabled before buffer");
  a_ramp_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(paBufEn_q) |-> !paEn_q)
    else $error("buffer and amplifier enabled together");
  a_block_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    rxPathBlock_q |=> !frameAccept_q || $past(!rxPathBlock_q))
    else $error("frame accepted while blocked");
  a_block_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == RRTP_BUSYRX && !rxFrameEnd) |=> state_q == RRTP_BUSYRX)
    else $error("ongoing reception disturbed");
  a_thresh_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == RRTP_RXON && syncDetect && !rxPathBlock_q && rxDetectThreshold_q == 4'h0)
    |=> frameAccept_q)
    else $error("frame dropped with zero threshold");
  a_thresh_weak: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rxDetectThreshold_q != 4'h0 && !strongEnough) |=> !frameAccept_q || $past(strongEnough))
    else $error("weak frame accepted");
  a_ignore_trig: assert property (@(posedge ref_clk) disable iff (!nrst)
    (trigEdge && (state_q == RRTP_RXON || state_q == RRTP_IDLE) && !cmdStrobe)
    |=> state_q != RRTP_BUSYTX)
    else $error("trigger honoured in wrong state");
  a_level_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    (doWrite && awAddr_q == RRTP_TXPWR_ADDR) |=> txOutputLevel_q == $past(wData_q[3:0]))
    else $error("output level not stored");
  // The amplifier may only rise after the buffer has stood on for at least a cycle.
  sequence s_pa_rise;
    $rose(paEn_q);
  endsequence
  a_pa_after_buf: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_pa_rise |-> $past(paBufEn_q))
    else $error("amplifier rose without a settled buffer");
  // Outside a transmission the buffer and amplifier are off from the second cycle on, so no stray power leaks out.
  a_ramp_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q != RRTP_BUSYTX && $past(state_q) != RRTP_BUSYTX) |-> !paBufEn_q && !paEn_q)
    else $error("ramp active outside a transmission");
  // A start command outside the locked and retry states never starts a frame.
  a_cmd_ignore: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cmdStrobe && cmdCode == RRTP_CMD_TX_START &&
     !(state_q inside {RRTP_LOCKED, RRTP_ARETON, RRTP_BUSYTX})) |=> state_q != RRTP_BUSYTX)
    else $error("start command honoured in the wrong state");
  // An accepted frame always has a detected header behind it.
  a_accept_hdr: assert property (@(posedge ref_clk) disable iff (!nrst)
    frameAccept_q |-> $past(syncDetect) && state_q == RRTP_BUSYRX)
    else $error("frame accepted without a header");
  // A header stronger than the programmed limit is taken whatever the nonzero code is.
  a_thresh_strong: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == RRTP_RXON && syncDetect && !rxPathBlock_q && rxDetectThreshold_q != 4'h0 &&
     int'(frameStrengthDbm) > FLOOR_DBM + RRTP_STEP_DB * (int'(rxDetectThreshold_q) - 1))
    |=> frameAccept_q)
    else $error("strong frame dropped");
  // A frame in flight ends on its own end pulse and returns to listening.
  a_rx_end: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_q == RRTP_BUSYRX && rxFrameEnd) |=> state_q == RRTP_RXON)
    else $error("ongoing reception not completed");
endmodule

// ---- rrtp_pkg.sv ----
// Package for the receive gate and transmit power control block.
// Assumes a 50 MHz ref_clk and a 32-bit AXI4-Lite register bus.
package rrtp_pkg;
  // Register indices; each register is one aligned word, so its byte address is four times this.
  localparam logic [7:0] RRTP_TXPWR_IDX = 8'h05;
  localparam logic [7:0] RRTP_RXSYN_IDX = 8'h15;
  localparam logic [7:0] RRTP_CMD_IDX = 8'h02;
  localparam logic [7:0] RRTP_STAT_IDX = 8'h03;
  // Register byte addresses.
  localparam logic [7:0] RRTP_TXPWR_ADDR = {RRTP_TXPWR_IDX[5:0], 2'b00};
  localparam logic [7:0] RRTP_RXSYN_ADDR = {RRTP_RXSYN_IDX[5:0], 2'b00};
  localparam logic [7:0] RRTP_CMD_ADDR = {RRTP_CMD_IDX[5:0], 2'b00};
  localparam logic [7:0] RRTP_STAT_ADDR = {RRTP_STAT_IDX[5:0], 2'b00};
  // Field positions.
  localparam int RRTP_BLOCK_BIT = 7;
  localparam int RRTP_AUTOCRC_BIT = 7;
  // Reset values.
  localparam logic [3:0] RRTP_LEVEL_RST = 4'h0;
  localparam logic [3:0] RRTP_THRESH_RST = 4'h0;
  localparam logic RRTP_BLOCK_RST = 1'b0;
  // Command codes written to the command field.
  localparam logic [4:0] RRTP_CMD_TX_START = 5'h02;
  localparam logic [4:0] RRTP_CMD_PLL_ON = 5'h09;
  localparam logic [4:0] RRTP_CMD_RX_ON = 5'h06;
  localparam logic [4:0] RRTP_CMD_ARET_ON = 5'h19;
  localparam logic [4:0] RRTP_CMD_AACK_ON = 5'h16;
  // Threshold step in dB.
  localparam int RRTP_STEP_DB = 3;
  // Timing of the transmit start.
  localparam int RRTP_CLK_MHZ = 50;
  localparam int RRTP_MOD_US = 16;
  localparam int RRTP_MOD_CYC = RRTP_MOD_US * RRTP_CLK_MHZ;
  localparam int RRTP_BUF_CYC = RRTP_MOD_CYC / 4;
  localparam int RRTP_PA_CYC = RRTP_MOD_CYC / 2;
  // Transceiver states.
  typedef enum logic [2:0] {
    RRTP_IDLE = 3'b000,
    RRTP_LOCKED = 3'b001,
    RRTP_RXON = 3'b010,
    RRTP_BUSYRX = 3'b011,
    RRTP_BUSYTX = 3'b100,
    RRTP_ARETON = 3'b101,
    RRTP_AACKON = 3'b110
  } rrtp_state_t;
endpackage

// ---- rrtp_host.sv ----
// Host model: AXI4-Lite master for the registers and the trigger pin driver.
// Assumes a free-running ref_clk; a bus that never answers ends the run.
module rrtp_host (
  input wire logic ref_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic trigPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Everything idles low so nothing is requested before reset ends.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, trigPin} = '0;
  end
  // Address and data go out together; each drops once taken, in either order.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n == 50) test_radio_rx_gate_tx_power_ctrl.complete_run(1);
    // One idle edge between calls, so no handshake signal is assigned twice in a step.
    @(posedge ref_clk);
  endtask
  // Read data and response are taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50) test_radio_rx_gate_tx_power_ctrl.complete_run(1);
    @(posedge ref_clk);
  endtask
  // The pin is a level; the device acts only on its rising edge.
  task automatic trig(input logic v);
    trigPin <= v;
  endtask
endmodule

// ---- test_radio_rx_gate_tx_power_ctrl.sv ----
// Bench for the receive gate and transmit power control block.
// Assumes rrtp_host drives the register bus and the trigger pin.
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_radio_rx_gate_tx_power_ctrl;
  import rrtp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // A short modulation delay keeps the run brief; the ramp scales with it.
  localparam int MC = 40;
  logic ref_clk;
  logic nrst;
  logic syncDetect;
  logic signed [7:0] frameStrengthDbm;
  logic rxFrameEnd;
  logic txFrameEnd;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, txOutputLevel_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic trigPin, frameAccept_q, paBufEn_q, paEn_q, modulate_q;
  int nTests = 0;
  int miscompares = 0;
  rrtp_host host (.ref_clk(ref_clk), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trigPin(trigPin));
  rrtp_ctrl #(.MOD_CYC(MC)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_tx_trigger_pin(trigPin), .syncDetect(syncDetect),
    .frameStrengthDbm(frameStrengthDbm), .rxFrameEnd(rxFrameEnd), .txFrameEnd(txFrameEnd),
    .frameAccept_q(frameAccept_q), .txOutputLevel_q(txOutputLevel_q),
    .paBufEn_q(paBufEn_q), .paEn_q(paEn_q), .modulate_q(modulate_q));
  // A 20 ns period gives the 50 MHz reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic complete_run(input int hung);
    miscompares += hung;
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, {24'h0, v}, 4'hF, r);
  endtask
  task automatic st(input rrtp_state_t e);
    host.rd(RRTP_STAT_ADDR, d, r);
    `CHK(d[2:0], e)
  endtask
  // One header pulse; an accept pulse is looked for over the next cycles.
  task automatic frame(input int s, input logic e);
    logic seen;
    seen = 1'b0;
    syncDetect <= 1'b1;
    frameStrengthDbm <= 8'(s);
    @(posedge ref_clk);
    syncDetect <= 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      seen |= frameAccept_q;
    end
    `CHK(seen, e)
  endtask
  task automatic pulseEnd(input logic tx);
    if (tx) txFrameEnd <= 1'b1;
    else rxFrameEnd <= 1'b1;
    @(posedge ref_clk);
    {txFrameEnd, rxFrameEnd} <= 2'b00;
    @(posedge ref_clk);
  endtask
  task automatic s_regs();
    host.rd(RRTP_TXPWR_ADDR, d, r);
    `CHK(d[7:0], 8'h00)
    host.rd(RRTP_RXSYN_ADDR, d, r);
    `CHK(d[7:0], 8'h00)
    host.rd(8'h40, d, r);
    `CHK({r, d}, {2'b10, 32'h0})
    for (int i = 0; i < 16; i++) begin
      w(RRTP_TXPWR_ADDR, 8'h80 | 8'(i));
      host.rd(RRTP_TXPWR_ADDR, d, r);
      `CHK({d[3:0], txOutputLevel_q}, {4'(i), 4'(i)})
    end
    // A write without the low byte lane must leave the level alone.
    host.wr(RRTP_TXPWR_ADDR, 32'h00000003, 4'hE, r);
    `CHK(txOutputLevel_q, 4'hF)
  endtask
  // Thresholds 1, 14 and 15 are probed at their limit and one dB above it.
  task automatic s_thresh();
    int lim;
    int ts[3] = '{1, 14, 15};
    w(RRTP_CMD_ADDR, {3'h0, RRTP_CMD_RX_ON});
    st(RRTP_RXON);
    frame(-128, 1'b1);
    pulseEnd(1'b0);
    foreach (ts[k]) begin
      lim = -91 + RRTP_STEP_DB * (ts[k] - 1);
      w(RRTP_RXSYN_ADDR, 8'(ts[k]));
      frame(lim, 1'b0);
      frame(lim + 1, 1'b1);
      pulseEnd(1'b0);
    end
  endtask
  task automatic s_block();
    w(RRTP_RXSYN_ADDR, 8'h8F);
    frame(0, 1'b0);
    w(RRTP_RXSYN_ADDR, 8'h00);
    frame(0, 1'b1);
    w(RRTP_RXSYN_ADDR, 8'h80);
    st(RRTP_BUSYRX);
    pulseEnd(1'b0);
    st(RRTP_RXON);
    frame(0, 1'b0);
    w(RRTP_RXSYN_ADDR, 8'h00);
  endtask
  task automatic s_tx();
    int b, p, m;
    host.trig(1'b1);
    w(RRTP_CMD_ADDR, {3'h0, RRTP_CMD_TX_START});
    st(RRTP_RXON);
    host.trig(1'b0);
    w(RRTP_CMD_ADDR, {3'h0, RRTP_CMD_PLL_ON});
    st(RRTP_LOCKED);
    host.trig(1'b1);
    {b, p, m} = '0;
    for (int n = 1; n < 3 * MC && m == 0; n++) begin
      @(posedge ref_clk);
      if (paBufEn_q && b == 0) b = n;
      if (paEn_q && p == 0) p = n;
      if (modulate_q) m = n;
    end
    `CHK(m inside {MC, MC + 1, MC + 2}, 1'b1)
    `CHK(b > 0 && b < p && p < m, 1'b1)
    host.trig(1'b0);
    st(RRTP_BUSYTX);
    pulseEnd(1'b1);
    w(RRTP_CMD_ADDR, {3'h0, RRTP_CMD_ARET_ON});
    st(RRTP_ARETON);
    w(RRTP_CMD_ADDR, {3'h0, RRTP_CMD_TX_START});
    st(RRTP_BUSYTX);
    repeat (MC) @(posedge ref_clk);
    `CHK(modulate_q, 1'b1)
    pulseEnd(1'b1);
    w(RRTP_CMD_ADDR, {3'h0, RRTP_CMD_AACK_ON});
    st(RRTP_AACKON);
    frame(-100, 1'b1);
  endtask
  initial begin
    {nrst, syncDetect, rxFrameEnd, txFrameEnd} = 4'h0;
    frameStrengthDbm = 8'sh00;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    `CHK(txOutputLevel_q, 4'h0)
    s_regs();
    s_thresh();
    s_block();
    s_tx();
    complete_run(0);
  end
endmodule
